// [design/wsq_pkg.sv]
// How it works
// - write-block request in cycle 1 raises tag output enable and processor data enable
// - cycle 2 decodes address bit 33 clear as cacheable memory space
// - cycle 2 raises system data output enable to hold processor enable
// - cycle 2 raises tag output enable enable so tag bus never floats
// - cycle 2 raises write-data select to ask for second octaword
// - cycle 3 drops early enable, system data enable and write-data select
// - victim found by cycle 2 tag read is processed before the fill
// - cycle 4 raises cache data output enable on the phase-one fall edge
// - cycle 5 latches first victim octaword and raises cache address bit 4
// - cycle 6 drops tag and data output enable enables after second victim
// - cycle 7 drives valid/dirty tag and raises data and tag write enables
// - cycle 8 drives fill data; partial writes merge a memory line first
// - cycle 8 raises processor data cache invalidate request
// - second fill octaword moves address bit 4 on the phase-two rise edge
// - cycle 9 writes second fill octaword, then address bit 4 drops
// - cycle 10 acknowledges the cycle and returns cache controls to default
// - cycle 11 ends it; a new request is accepted at once
// - sequence only for cacheable, victim, allocate enabled; else handed off
package wsq_pkg;
   localparam int          CLK_PERIOD_NS  = 25;
   localparam int          SEQ_CYCLES     = 12;
   // processor cycle request and acknowledge encodings
   localparam logic [2:0]  REQ_WRITE_BLK  = 3'h6;
   localparam logic [2:0]  ACK_IDLE       = 3'h0;
   localparam logic [2:0]  ACK_OK         = 3'h1;
   // cacheable memory space when this address bit is clear
   localparam int          IO_SPACE_BIT   = 33;
   // tag state field: {valid, dirty}
   localparam logic [1:0]  TAG_VALID_DIRTY = 2'h3;
   localparam logic [1:0]  TAG_NONE        = 2'h0;
   // wishbone register byte offsets
   localparam logic [7:0]  CTRL_OFFSET    = 8'h00;
   localparam logic [7:0]  STATUS_OFFSET  = 8'h04;
   localparam logic [7:0]  COUNT_OFFSET   = 8'h08;
   // control fields and reset
   localparam int          CTRL_ALLOC_BIT = 0;
   localparam int          CTRL_CACHE_BIT = 1;
   localparam logic [1:0]  CTRL_RESET     = 2'h3;
   // status fields
   localparam int          STAT_CYCLE_LSB = 0;
   localparam int          STAT_HOLD_BIT  = 4;
   localparam int          STAT_MERGE_BIT = 5;

   typedef enum logic [3:0] {
      ST_IDLE, ST_C1, ST_C2, ST_C3, ST_C4, ST_C5, ST_C6,
      ST_C7, ST_C8, ST_C9, ST_C10, ST_C11
   } wsq_state_type;
endpackage

// [design/wsq_write_block_victim_sequencer.sv]
`timescale 1ns/1ps
module wsq_write_block_victim_sequencer (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // wishbone slave
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [7:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic [31:0]       wb_dat_o,
   output logic              wb_ack_o,
   // processor side
   input  wire logic [2:0]   proc_cycle_request_i,
   input  wire logic [33:5]  system_address_i,
   input  wire logic         full_line_write_i,
   output logic              early_output_enable_o,
   output logic              cache_tag_output_enable_o,
   output logic              proc_data_output_enable_n_o,
   output logic              system_data_output_enable_o,
   output logic              proc_write_data_select_o,
   output logic              proc_dcache_invalidate_request_o,
   output logic [2:0]        proc_cycle_acknowledge_o,
   // cache sram side
   input  wire logic         tag_victim_i,
   output logic              tag_output_enable_enable_o,
   output logic              cache_data_output_enable_enable_o,
   output logic              data_oe_phase_one_fall_o,
   output logic              cache_data_address4_o,
   output logic              address4_phase_two_rise_o,
   output logic              cache_data_write_enable_enable_o,
   output logic              cache_tag_write_enable_o,
   output logic [1:0]        tag_state_o,
   output logic              tag_state_drive_o,
   // data path companion
   input  wire logic         merge_done_i,
   input  wire logic         victim_written_back_i,
   output logic              latch_write_data_o,
   output logic              latch_victim_o,
   output logic              drive_fill_o,
   output logic              fill_merge_o,
   output logic              victim_hold_o,
   output logic              other_sequence_o
);

   wsq_pkg::wsq_state_type state_r;
   wsq_pkg::wsq_state_type state_nxt;
   logic [1:0]  ctrl_r;
   logic [15:0] count_r;
   logic        merge_r;

   // request and decode
   wire req_wb    = proc_cycle_request_i == wsq_pkg::REQ_WRITE_BLK;
   wire cacheable = !system_address_i[wsq_pkg::IO_SPACE_BIT]
                    && ctrl_r[wsq_pkg::CTRL_CACHE_BIT];
   wire this_case = cacheable && tag_victim_i
                    && ctrl_r[wsq_pkg::CTRL_ALLOC_BIT];
   wire at_idle   = state_r == wsq_pkg::ST_IDLE
                    || state_r == wsq_pkg::ST_C11;
   wire fill_wait = !full_line_write_i && !merge_done_i;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         wsq_pkg::ST_IDLE, wsq_pkg::ST_C11: begin
            state_nxt = req_wb ? wsq_pkg::ST_C1 : wsq_pkg::ST_IDLE;
         end
         wsq_pkg::ST_C1:  state_nxt = wsq_pkg::ST_C2;
         wsq_pkg::ST_C2: begin
            state_nxt = this_case ? wsq_pkg::ST_C3 : wsq_pkg::ST_IDLE;
         end
         wsq_pkg::ST_C3:  state_nxt = wsq_pkg::ST_C4;
         wsq_pkg::ST_C4:  state_nxt = wsq_pkg::ST_C5;
         wsq_pkg::ST_C5:  state_nxt = wsq_pkg::ST_C6;
         wsq_pkg::ST_C6:  state_nxt = wsq_pkg::ST_C7;
         wsq_pkg::ST_C7:  state_nxt = wsq_pkg::ST_C8;
         wsq_pkg::ST_C8: begin
            state_nxt = fill_wait ? wsq_pkg::ST_C8 : wsq_pkg::ST_C9;
         end
         wsq_pkg::ST_C9:  state_nxt = wsq_pkg::ST_C10;
         wsq_pkg::ST_C10: state_nxt = wsq_pkg::ST_C11;
         default:         state_nxt = wsq_pkg::ST_IDLE;
      endcase
   end

   // output decode from the next state so every output is a flop
   wire n_c1  = state_nxt == wsq_pkg::ST_C1;
   wire n_c2  = state_nxt == wsq_pkg::ST_C2;
   wire n_c3  = state_nxt == wsq_pkg::ST_C3;
   wire n_c4  = state_nxt == wsq_pkg::ST_C4;
   wire n_c5  = state_nxt == wsq_pkg::ST_C5;
   wire n_c6  = state_nxt == wsq_pkg::ST_C6;
   wire n_c7  = state_nxt == wsq_pkg::ST_C7;
   wire n_c8  = state_nxt == wsq_pkg::ST_C8;
   wire n_c9  = state_nxt == wsq_pkg::ST_C9;
   wire n_c10 = state_nxt == wsq_pkg::ST_C10;
   wire n_vic = n_c3 || n_c4 || n_c5 || n_c6 || n_c7 || n_c8 || n_c9;

   wire early_nxt  = !n_vic;
   wire tag_oe_nxt = n_c1 || n_c2 || n_c3 || n_c4 || n_c5;
   wire pdoe_nxt   = n_c1 || n_c2;
   wire tag_en_nxt = n_c2 || n_c3 || n_c4 || n_c5;
   wire doe_en_nxt = n_c4 || n_c5;
   wire a4_nxt     = n_c5 || n_c6 || n_c8 || n_c9;
   wire dwe_nxt    = n_c7 || n_c8 || n_c9;
   wire fill_nxt   = n_c8 || n_c9;
   // merge flag is being captured on the edge that enters cycle 8
   wire merge_now  = state_r == wsq_pkg::ST_C7 ? !full_line_write_i
                                               : merge_r;
   wire merge_nxt  = fill_nxt && merge_now;
   wire other_nxt  = state_r == wsq_pkg::ST_C2 && !this_case;
   wire hold_set   = state_r == wsq_pkg::ST_C6;
   wire [1:0] tag_nxt = n_c7 ? wsq_pkg::TAG_VALID_DIRTY : wsq_pkg::TAG_NONE;
   wire [2:0] ack_nxt = n_c10 ? wsq_pkg::ACK_OK : wsq_pkg::ACK_IDLE;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= wsq_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         early_output_enable_o       <= 1'b1;
         cache_tag_output_enable_o   <= 1'b0;
         proc_data_output_enable_n_o <= 1'b1;
         system_data_output_enable_o <= 1'b0;
         proc_write_data_select_o    <= 1'b0;
         tag_output_enable_enable_o  <= 1'b0;
      end else begin
         early_output_enable_o       <= early_nxt;
         cache_tag_output_enable_o   <= tag_oe_nxt;
         proc_data_output_enable_n_o <= !pdoe_nxt;
         system_data_output_enable_o <= n_c2;
         proc_write_data_select_o    <= n_c2;
         tag_output_enable_enable_o  <= tag_en_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cache_data_output_enable_enable_o <= 1'b0;
         data_oe_phase_one_fall_o          <= 1'b0;
         cache_data_address4_o             <= 1'b0;
         address4_phase_two_rise_o         <= 1'b0;
         cache_data_write_enable_enable_o  <= 1'b0;
         cache_tag_write_enable_o          <= 1'b0;
      end else begin
         cache_data_output_enable_enable_o <= doe_en_nxt;
         data_oe_phase_one_fall_o          <= n_c4;
         cache_data_address4_o             <= a4_nxt;
         address4_phase_two_rise_o         <= fill_nxt;
         cache_data_write_enable_enable_o  <= dwe_nxt;
         cache_tag_write_enable_o          <= n_c7;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tag_state_o                      <= wsq_pkg::TAG_NONE;
         tag_state_drive_o                <= 1'b0;
         proc_dcache_invalidate_request_o <= 1'b0;
         proc_cycle_acknowledge_o         <= wsq_pkg::ACK_IDLE;
         latch_write_data_o               <= 1'b0;
         latch_victim_o                   <= 1'b0;
      end else begin
         tag_state_o                      <= tag_nxt;
         tag_state_drive_o                <= n_c7;
         proc_dcache_invalidate_request_o <= n_c8;
         proc_cycle_acknowledge_o         <= ack_nxt;
         latch_write_data_o               <= n_c2 || n_c3;
         latch_victim_o                   <= n_c5 || n_c6;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_fill_o     <= 1'b0;
         fill_merge_o     <= 1'b0;
         other_sequence_o <= 1'b0;
         merge_r          <= 1'b0;
      end else begin
         drive_fill_o     <= fill_nxt;
         fill_merge_o     <= merge_nxt;
         other_sequence_o <= other_nxt;
         if (state_r == wsq_pkg::ST_C7) begin
            merge_r <= !full_line_write_i;
         end
      end
   end

   // victim hold: set wins over the writeback clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         victim_hold_o <= 1'b0;
      end else if (hold_set) begin
         victim_hold_o <= 1'b1;
      end else if (victim_written_back_i) begin
         victim_hold_o <= 1'b0;
      end
   end

   // wishbone slave, one wait state
   wire        wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire        sel_ctrl = wb_adr_i == wsq_pkg::CTRL_OFFSET;
   wire        sel_stat = wb_adr_i == wsq_pkg::STATUS_OFFSET;
   wire        sel_cnt  = wb_adr_i == wsq_pkg::COUNT_OFFSET;
   wire        ctrl_wr  = wb_req && wb_we_i && sel_ctrl && wb_sel_i[0];
   wire [31:0] stat_val = {26'h0, merge_r, victim_hold_o,
                           4'(state_r)};
   wire [31:0] rd_val   = sel_ctrl ? {30'h0, ctrl_r}
                        : sel_stat ? stat_val
                        : sel_cnt  ? {16'h0, count_r}
                        : 32'h0;
   wire        seq_done = state_r == wsq_pkg::ST_C10;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         ctrl_r   <= wsq_pkg::CTRL_RESET;
         count_r  <= 16'h0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_val : 32'h0;
         if (ctrl_wr) begin
            ctrl_r <= wb_dat_i[1:0];
         end
         if (seq_done) begin
            count_r <= count_r + 16'h1;
         end
      end
   end

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence victim_read_s;
      cache_data_output_enable_enable_o && data_oe_phase_one_fall_o
      ##1 cache_data_address4_o && latch_victim_o
      ##1 !tag_output_enable_enable_o && !cache_data_output_enable_enable_o;
   endsequence

   sequence fill_tail_s;
      cache_data_address4_o && cache_data_write_enable_enable_o
      ##1 !cache_data_address4_o
          && proc_cycle_acknowledge_o == wsq_pkg::ACK_OK
      ##1 proc_cycle_acknowledge_o == wsq_pkg::ACK_IDLE;
   endsequence

   request_taken_a: assert property (
      at_idle && req_wb |=> cache_tag_output_enable_o
                            && !proc_data_output_enable_n_o)
      else $error("request did not raise tag and data enables");

   decode_select_a: assert property (
      state_r == wsq_pkg::ST_C2 && this_case
      |=> state_r == wsq_pkg::ST_C3 && !early_output_enable_o)
      else $error("cacheable victim write not selected");

   cycle_two_a: assert property (
      state_r == wsq_pkg::ST_C2 |-> system_data_output_enable_o
         && tag_output_enable_enable_o && proc_write_data_select_o
         && latch_write_data_o)
      else $error("cycle two enables missing");

   cycle_three_a: assert property (
      $fell(proc_write_data_select_o) && state_r == wsq_pkg::ST_C3
      |-> !system_data_output_enable_o && proc_data_output_enable_n_o)
      else $error("cycle three release wrong");

   victim_read_a: assert property (
      state_r == wsq_pkg::ST_C3 |=> victim_read_s)
      else $error("victim read order wrong");

   tag_write_a: assert property (
      state_r == wsq_pkg::ST_C7 |-> cache_tag_write_enable_o
         && tag_state_o == wsq_pkg::TAG_VALID_DIRTY
         && cache_data_write_enable_enable_o && victim_hold_o)
      else $error("fill tag write wrong");

   fill_inval_a: assert property (
      $rose(drive_fill_o) |-> proc_dcache_invalidate_request_o
         && address4_phase_two_rise_o && cache_data_address4_o)
      else $error("fill without invalidate");

   fill_tail_a: assert property (
      state_r == wsq_pkg::ST_C9 |-> fill_tail_s)
      else $error("second fill or acknowledge wrong");

   full_length_a: assert property (
      state_r == wsq_pkg::ST_C7 && full_line_write_i
      |-> ##3 proc_cycle_acknowledge_o == wsq_pkg::ACK_OK)
      else $error("full line sequence length wrong");

   other_case_a: assert property (
      state_r == wsq_pkg::ST_C2 && !this_case
      |=> other_sequence_o && early_output_enable_o
          && state_r == wsq_pkg::ST_IDLE)
      else $error("non victim case not handed off");

   victim_keep_a: assert property (
      victim_hold_o && !victim_written_back_i |=> victim_hold_o)
      else $error("victim hold dropped early");

   proc_enable_a: assert property (
      state_r == wsq_pkg::ST_C1 |-> !proc_data_output_enable_n_o
         && cache_tag_output_enable_o && early_output_enable_o)
      else $error("cycle one enables wrong");

   early_drop_a: assert property (
      state_r == wsq_pkg::ST_C3 |-> !early_output_enable_o
         && !proc_write_data_select_o && !system_data_output_enable_o)
      else $error("cycle three enables still high");

   phase_one_a: assert property (
      data_oe_phase_one_fall_o |-> state_r == wsq_pkg::ST_C4
         && cache_data_output_enable_enable_o)
      else $error("phase one data enable out of place");

   victim_addr_a: assert property (
      state_r == wsq_pkg::ST_C5 |-> cache_data_address4_o
         && latch_victim_o && !latch_write_data_o)
      else $error("second victim octaword not selected");

   bus_release_a: assert property (
      state_r == wsq_pkg::ST_C6 |-> !tag_output_enable_enable_o
         && !cache_data_output_enable_enable_o
         && !cache_tag_output_enable_o)
      else $error("cache enables not released");

   tag_drive_a: assert property (
      tag_state_drive_o |-> cache_tag_write_enable_o
         && state_r == wsq_pkg::ST_C7)
      else $error("tag bus driven outside cycle seven");

   fill_wait_a: assert property (
      state_r == wsq_pkg::ST_C8 && !full_line_write_i && !merge_done_i
      |=> state_r == wsq_pkg::ST_C8 && drive_fill_o)
      else $error("partial fill did not wait for merge");

   merge_flag_a: assert property (
      $rose(drive_fill_o) |-> fill_merge_o == merge_r)
      else $error("merge flag stale at fill start");

   inval_place_a: assert property (
      proc_dcache_invalidate_request_o |-> state_r == wsq_pkg::ST_C8
         && drive_fill_o)
      else $error("invalidate outside the fill");

   write_timing_a: assert property (
      address4_phase_two_rise_o |-> cache_data_address4_o && drive_fill_o)
      else $error("write timing flag without fill address");

   write_window_a: assert property (
      cache_data_write_enable_enable_o |-> state_r == wsq_pkg::ST_C7
         || state_r == wsq_pkg::ST_C8 || state_r == wsq_pkg::ST_C9)
      else $error("data write enable outside the fill");

   ack_place_a: assert property (
      proc_cycle_acknowledge_o != wsq_pkg::ACK_IDLE
      |-> state_r == wsq_pkg::ST_C10)
      else $error("acknowledge outside cycle ten");

   controls_default_a: assert property (
      state_r == wsq_pkg::ST_C10 |-> early_output_enable_o
         && !cache_data_address4_o && !cache_tag_output_enable_o
         && !drive_fill_o && !cache_data_write_enable_enable_o)
      else $error("cache controls not back to default");

   next_ready_a: assert property (
      state_r == wsq_pkg::ST_C11 && req_wb |=> state_r == wsq_pkg::ST_C1)
      else $error("next request not taken at once");

endmodule // wsq_write_block_victim_sequencer

// [dv/tb_wsq_write_block_victim_sequencer.sv]
`timescale 1ns/1ps
module tb_wsq_write_block_victim_sequencer;
   logic         clk_i = 1'b0;
   logic         rst_i = 1'b1;
   logic         cyc = 1'b0;
   logic         stb = 1'b0;
   logic         we = 1'b0;
   logic [7:0]   adr = 8'h00;
   logic [31:0]  wdat = 32'h0;
   logic [31:0]  rdat;
   logic [31:0]  dat_o;
   logic         ack;
   logic         start = 1'b0;
   logic         keep = 1'b1;
   logic         hold = 1'b0;
   logic         io = 1'b0;
   logic         victim = 1'b1;
   logic         full = 1'b1;
   logic [3:0]   delay = 4'h0;
   logic [2:0]   req, cack;
   logic [1:0]   tst;
   logic         early, tagoe, doe_n, sdoe, wsel, inval, toee, doee, ph1f;
   logic         a4, ph2r, dwe, twe, tdrv, lwd, lv, dfill, fmrg, vhold;
   logic         oseq, mdone, wback;
   logic [3:0]   octs;
   int           err_count = 0;
   int           cmp_count = 0;
   wire  [22:0]  obs = {early, tagoe, doe_n, sdoe, wsel, inval, cack, toee,
      doee, ph1f, a4, ph2r, dwe, twe, tst, tdrv, lwd, lv, dfill, fmrg};

   initial forever #12.5 clk_i = ~clk_i;

   wsq_write_block_victim_sequencer dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .proc_cycle_request_i(req),
      .system_address_i({io, 28'h0000123}), .full_line_write_i(full),
      .early_output_enable_o(early), .cache_tag_output_enable_o(tagoe),
      .proc_data_output_enable_n_o(doe_n),
      .system_data_output_enable_o(sdoe), .proc_write_data_select_o(wsel),
      .proc_dcache_invalidate_request_o(inval),
      .proc_cycle_acknowledge_o(cack), .tag_victim_i(victim),
      .tag_output_enable_enable_o(toee),
      .cache_data_output_enable_enable_o(doee),
      .data_oe_phase_one_fall_o(ph1f), .cache_data_address4_o(a4),
      .address4_phase_two_rise_o(ph2r),
      .cache_data_write_enable_enable_o(dwe),
      .cache_tag_write_enable_o(twe), .tag_state_o(tst),
      .tag_state_drive_o(tdrv), .merge_done_i(mdone),
      .victim_written_back_i(wback), .latch_write_data_o(lwd),
      .latch_victim_o(lv), .drive_fill_o(dfill), .fill_merge_o(fmrg),
      .victim_hold_o(vhold), .other_sequence_o(oseq));

   wsq_proc_model proc (
      .clk_i(clk_i), .rst_i(rst_i), .start_i(start), .keep_i(keep),
      .hold_i(hold), .delay_i(delay), .ack_i(cack), .doe_n_i(doe_n),
      .wsel_i(wsel), .inval_i(inval), .vhold_i(vhold), .req_o(req),
      .merge_done_o(mdone), .wback_o(wback), .octs_o(octs));

   function automatic logic [22:0] exp_of(input int c, input logic f);
      exp_of = {c < 3 || c > 9, c >= 1 && c <= 5, !(c == 1 || c == 2),
         c == 2, c == 2, c == 8, (c == 10) ? wsq_pkg::ACK_OK : 3'h0,
         c >= 2 && c <= 5, c == 4 || c == 5, c == 4,
         c == 5 || c == 6 || c == 8 || c == 9, c == 8 || c == 9,
         c >= 7 && c <= 9, c == 7,
         (c == 7) ? wsq_pkg::TAG_VALID_DIRTY : 2'h0, c == 7,
         c == 2 || c == 3, c == 5 || c == 6, c == 8 || c == 9,
         (c == 8 || c == 9) && !f};
   endfunction

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (ack !== 1'b1 && i < 20);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (i >= 20) begin
         err_count++;
         end_of_test();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(rdat, e, "register read");
   endtask

   // one-cycle start; model then holds request as keep says
   task automatic launch(input logic k, b, f, i, v, input logic [3:0] d);
      @(posedge clk_i);
      start <= 1'b1;
      keep <= k;
      hold <= b;
      full <= f;
      io <= i;
      victim <= v;
      delay <= d;
      @(posedge clk_i);
      start <= 1'b0;
   endtask

   task automatic seq(input int n, input logic b, f, input logic [3:0] d);
      int c, k;
      launch(1'b1, b, f, 1'b0, 1'b1, d);
      for (k = 1; k <= n; k++) begin
         @(posedge clk_i);
         if (k == 12)
            hold <= 1'b0;
         @(negedge clk_i);
         c = k <= 8 ? k : (k <= 8 + d ? 8 : k - d);
         c = c > 11 ? c - 11 : c;
         chk(obs, exp_of(c, f), "outputs");
         if (c >= 7 && c <= 10)
            chk(vhold, 1'b1, "victim hold");
      end
      chk(octs, (n > 14) ? 32'h4 : 32'h2, "write octawords");
   endtask

   initial begin
      int i, k, p;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk(obs, exp_of(0, 1'b1), "idle");
      rd(wsq_pkg::CTRL_OFFSET, 32'h3);
      rd(wsq_pkg::STATUS_OFFSET, 32'h0);
      rd(wsq_pkg::COUNT_OFFSET, 32'h0);
      wb(1'b1, 8'h40, 32'hFFFFFFFF);
      rd(8'h40, 32'h0);
      rd(wsq_pkg::CTRL_OFFSET, 32'h3);
      $display("test registers done");
      seq(11, 1'b0, 1'b1, 4'h0);
      rd(wsq_pkg::STATUS_OFFSET, 32'h10);
      repeat (10) @(posedge clk_i);
      chk(vhold, 1'b0, "hold cleared");
      $display("test full line done");
      seq(14, 1'b0, 1'b0, 4'h3);
      rd(wsq_pkg::STATUS_OFFSET, 32'h20);
      $display("test partial merge done");
      seq(22, 1'b1, 1'b1, 4'h0);
      $display("test back to back done");
      for (i = 0; i < 4; i++) begin
         wb(1'b1, wsq_pkg::CTRL_OFFSET, (i == 2) ? 32'h2 : (i == 3) ? 32'h1 : 32'h3);
         launch(1'b0, 1'b0, 1'b1, i == 0, i != 1, 4'h0);
         p = 0;
         for (k = 0; k < 16; k++) begin
            @(negedge clk_i);
            if (oseq === 1'b1)
               p++;
            if (cack !== 3'h0)
               p += 10;
         end
         chk(p, 1, "handed off");
      end
      wb(1'b1, wsq_pkg::CTRL_OFFSET, 32'h3);
      rd(wsq_pkg::COUNT_OFFSET, 32'h4);
      $display("test other cases done");
      end_of_test();
   end

   initial begin
      #1250000;
      err_count++;
      end_of_test();
   end
endmodule // tb_wsq_write_block_victim_sequencer

// [dv/wsq_proc_model.sv]
`timescale 1ns/1ps
module wsq_proc_model (
   // bench control
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         start_i,
   input  wire logic         keep_i,
   input  wire logic         hold_i,
   input  wire logic [3:0]   delay_i,
   // from sequencer
   input  wire logic [2:0]   ack_i,
   input  wire logic         doe_n_i,
   input  wire logic         wsel_i,
   input  wire logic         inval_i,
   input  wire logic         vhold_i,
   // to sequencer, octaword count to bench
   output logic [2:0]        req_o,
   output logic              merge_done_o,
   output logic              wback_o,
   output logic [3:0]        octs_o
);
   logic [3:0]   wait_r;
   logic [3:0]   hold_r;
   assign merge_done_o = wait_r >= delay_i;
   always_ff @(posedge clk_i) begin
      if (rst_i)
         req_o <= 3'h0;
      else if (start_i)
         req_o <= wsq_pkg::REQ_WRITE_BLK;
      else if (!keep_i || (ack_i == wsq_pkg::ACK_OK && !hold_i))
         req_o <= 3'h0;
      wait_r <= inval_i ? wait_r + 4'h1 : 4'h0;
      hold_r <= vhold_i ? hold_r + 4'h1 : 4'h0;
      // written back some cycles after the hold shows
      wback_o <= hold_r == 4'h6;
      // one write octaword placed per enable or select seen
      if (rst_i || start_i)
         octs_o <= 4'h0;
      else if (!doe_n_i || wsel_i)
         octs_o <= octs_o + 4'h1;
   end
endmodule // wsq_proc_model
